// ---- swrs_defs.svh ----
// constants for the status write and ready signalling command block
// assumes inclusion by swrs_top.sv only; swrs_pkg.sv does not include it
`ifndef SWRS_DEFS_SVH
`define SWRS_DEFS_SVH
`define SWRS_OP_WRSB1     8'h01
`define SWRS_OP_WRSB2     8'h31
`define SWRS_OP_READY     8'h25
`define SWRS_B1_LOCK_BIT  7
`define SWRS_B1_CODE_HI   5
`define SWRS_B1_CODE_LO   2
`define SWRS_B2_CTL_BIT   7
`define SWRS_B2_EDGE_BIT  3
`define SWRS_B2_WIDTH_HI  1
`define SWRS_B2_WIDTH_LO  0
`define SWRS_RST_LOCK     1'b0
`define SWRS_RST_WEL      1'b0
`define SWRS_RST_CTL      1'b0
`define SWRS_RST_EDGE     1'b0
`define SWRS_RST_WIDTH    2'h0
`define SWRS_OP_BITS      5'h08
`define SWRS_FULL_BITS    5'h10
`define SWRS_DUMMY_WIDE   3'h4
`define SWRS_SO_LANE      1
`endif

// ---- swrs_pkg.sv ----
// types for the status write and ready signalling command block
// assumes swrs_defs.svh is compiled alongside
package swrs_pkg;
  typedef enum logic [1:0] {
    SWRS_W_SINGLE = 2'h0,
    SWRS_W_QUAD   = 2'h1,
    SWRS_W_OCTAL  = 2'h2
  } swrs_width_e;

  // gray coded along opcode, data, dummy, ready
  typedef enum logic [1:0] {
    SWRS_PH_OPC   = 2'h0,
    SWRS_PH_DATA  = 2'h1,
    SWRS_PH_DUMMY = 2'h3,
    SWRS_PH_READY = 2'h2
  } swrs_phase_e;

  typedef struct packed {
    logic        lock;
    logic        write_latch_flag;
    logic        ctl;
    logic        edge_rate;
    swrs_width_e width;
  } swrs_status_s;

  typedef struct packed {
    logic       req;
    logic [3:0] code;
    logic       prior_lock;
  } swrs_glob_s;
endpackage

// ---- swrs_top.sv ----
// serial flash command slice: status byte 1 and 2 writes, ready signalling
// assumes host keeps sck still while chip select is high
`timescale 1ns/10ps
`include "swrs_defs.svh"
module swrs_top (
  // core clock and control
  input  wire logic                 ref_clk_in,
  input  wire logic                 srst_in,
  input  wire logic                 ce_in,
  // serial link pins
  input  wire logic                 sck_in,
  input  wire logic                 cs_n_in,
  input  wire logic [7:0]           io_in,
  output logic      [7:0]           io_out,
  output logic      [7:0]           io_oe_out,
  input  wire logic                 wp_n_in,
  // device core side
  input  wire logic                 busy_in,
  input  wire logic                 wel_set_in,
  input  wire logic                 width_set_in,
  input  wire swrs_pkg::swrs_width_e width_val_in,
  output swrs_pkg::swrs_status_s    status_out,
  output swrs_pkg::swrs_glob_s      glob_out
);
  // link domain state
  logic                  start_lq;
  logic                  irq_lq;
  logic [15:0]           sh_lq;
  logic [4:0]            cnt_lq;
  logic [2:0]            mod_lq;
  logic [2:0]            dcnt_lq;
  logic [7:0]            op_lq;
  logic [7:0]            dat_lq;
  swrs_pkg::swrs_phase_e ph_lq;
  swrs_pkg::swrs_width_e wid_l1;
  swrs_pkg::swrs_width_e wid_l2;
  // link domain next values
  logic [15:0]           sh_d;
  logic [4:0]            cnt_d;
  logic [4:0]            base_cnt;
  logic [4:0]            step;
  logic [5:0]            sum;
  logic [2:0]            mod_d;
  logic [2:0]            dcnt_d;
  swrs_pkg::swrs_phase_e ph_d;
  swrs_pkg::swrs_phase_e base_ph;
  // core domain state
  logic                  csn_s1;
  logic                  csn_s2;
  logic                  csn_s3;
  logic                  irq_s1;
  logic                  irq_s2;
  logic                  start_s1;
  logic                  start_s2;
  logic                  seen_q;
  logic                  wp_s1;
  logic                  wp_s2;
  logic                  so_q;
  logic                  oe_q;
  swrs_pkg::swrs_status_s st_q;
  swrs_pkg::swrs_glob_s   glob_q;
  // frame end decode
  logic                  end_evt;
  logic                  op_ok;
  logic                  is_b1;
  logic                  is_b2;
  logic                  b1_full;
  logic                  b1_wp_block;
  logic                  b1_go;
  logic                  b2_go;

  // width setting is quasi static; host waits after changing it
  always_ff @(posedge sck_in)
  begin
    wid_l1 <= st_q.width;
    wid_l2 <= wid_l1;
  end

  // frame start marker, set while chip select is high
  always_ff @(posedge sck_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      start_lq <= 1'b1;
    else
      start_lq <= 1'b0;
  end

  always_comb
  begin
    case (wid_l2)
      swrs_pkg::SWRS_W_QUAD:  step = 5'h04;
      swrs_pkg::SWRS_W_OCTAL: step = 5'h08;
      default:                step = 5'h01;
    endcase
    base_cnt = start_lq ? 5'h00 : cnt_lq;
    base_ph  = start_lq ? swrs_pkg::SWRS_PH_OPC : ph_lq;
    sum      = {1'b0, base_cnt} + {1'b0, step};
    cnt_d    = (sum > {1'b0, `SWRS_FULL_BITS}) ? `SWRS_FULL_BITS : sum[4:0];
    mod_d    = (start_lq ? 3'h0 : mod_lq) + step[2:0];
    sh_d     = start_lq ? 16'h0000 : sh_lq;
    // extra bytes past the first data byte are never shifted in
    if (base_cnt < `SWRS_FULL_BITS && base_ph != swrs_pkg::SWRS_PH_DUMMY && base_ph != swrs_pkg::SWRS_PH_READY)
    begin
      case (wid_l2)
        swrs_pkg::SWRS_W_QUAD:  sh_d = {sh_d[11:0], io_in[3:0]};
        swrs_pkg::SWRS_W_OCTAL: sh_d = {sh_d[7:0], io_in};
        default:                sh_d = {sh_d[14:0], io_in[0]};
      endcase
    end
    ph_d   = base_ph;
    dcnt_d = start_lq ? 3'h0 : dcnt_lq;
    case (base_ph)
      swrs_pkg::SWRS_PH_OPC:
      begin
        if (cnt_d >= `SWRS_OP_BITS)
        begin
          if (sh_d[7:0] != `SWRS_OP_READY)
            ph_d = swrs_pkg::SWRS_PH_DATA;
          else if (wid_l2 == swrs_pkg::SWRS_W_SINGLE)
            ph_d = swrs_pkg::SWRS_PH_READY;
          else
            ph_d = swrs_pkg::SWRS_PH_DUMMY;
        end
      end
      swrs_pkg::SWRS_PH_DUMMY:
      begin
        dcnt_d = dcnt_d + 3'h1;
        if (dcnt_d == `SWRS_DUMMY_WIDE)
          ph_d = swrs_pkg::SWRS_PH_READY;
      end
      default:
        ph_d = base_ph;
    endcase
  end

  always_ff @(posedge sck_in)
  begin
    sh_lq   <= sh_d;
    cnt_lq  <= cnt_d;
    mod_lq  <= mod_d;
    ph_lq   <= ph_d;
    dcnt_lq <= dcnt_d;
    if (base_ph == swrs_pkg::SWRS_PH_OPC && cnt_d >= `SWRS_OP_BITS)
      op_lq <= sh_d[7:0];
    if (base_cnt < `SWRS_FULL_BITS && cnt_d == `SWRS_FULL_BITS && base_ph == swrs_pkg::SWRS_PH_DATA)
      dat_lq <= sh_d[7:0];
  end

  // ready mode flag dies with the frame itself
  always_ff @(posedge sck_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      irq_lq <= 1'b0;
    else if (ph_d == swrs_pkg::SWRS_PH_READY)
      irq_lq <= 1'b1;
  end

  // synchronisers into the core clock
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      csn_s1 <= 1'b1;
      csn_s2 <= 1'b1;
      csn_s3 <= 1'b1;
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      start_s1 <= 1'b1;
      start_s2 <= 1'b1;
      wp_s1  <= 1'b1;
      wp_s2  <= 1'b1;
    end
    else if (ce_in)
    begin
      csn_s1 <= cs_n_in;
      csn_s2 <= csn_s1;
      csn_s3 <= csn_s2;
      irq_s1 <= irq_lq;
      irq_s2 <= irq_s1;
      start_s1 <= start_lq;
      start_s2 <= start_s1;
      wp_s1  <= wp_n_in;
      wp_s2  <= wp_s1;
    end
  end

  // link words are stable once chip select is high and sck is still
  assign end_evt     = csn_s2 & ~csn_s3 & seen_q;
  assign op_ok       = cnt_lq >= `SWRS_OP_BITS;
  assign is_b1       = end_evt & op_ok & (op_lq == `SWRS_OP_WRSB1);
  assign is_b2       = end_evt & op_ok & (op_lq == `SWRS_OP_WRSB2);
  assign b1_full     = cnt_lq == `SWRS_FULL_BITS;
  assign b1_wp_block = ~wp_s2 & ~dat_lq[`SWRS_B1_LOCK_BIT];
  assign b1_go       = is_b1 & st_q.write_latch_flag & b1_full & ~b1_wp_block;
  assign b2_go       = is_b2 & st_q.write_latch_flag & (cnt_lq == `SWRS_FULL_BITS) & (mod_lq == 3'h0);

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      seen_q <= 1'b0;
    else if (ce_in)
    begin
      // frame had an sck edge; zero-clock frames leave no stale action
      if (csn_s2 && !csn_s3)
        seen_q <= 1'b0;
      else if (!csn_s2 && !start_s2)
        seen_q <= 1'b1;
    end
  end

  // write latch: a set in the same cycle beats the clear
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      st_q.write_latch_flag <= `SWRS_RST_WEL;
    else if (ce_in)
    begin
      if (wel_set_in)
        st_q.write_latch_flag <= 1'b1;
      else if (is_b1 || is_b2)
        st_q.write_latch_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      st_q.lock <= `SWRS_RST_LOCK;
    else if (ce_in && b1_go)
      st_q.lock <= dat_lq[`SWRS_B1_LOCK_BIT];
  end

  // global action request, carried out elsewhere
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      glob_q <= '0;
    else if (ce_in)
    begin
      glob_q.req <= b1_go;
      if (b1_go)
      begin
        glob_q.code       <= dat_lq[`SWRS_B1_CODE_HI:`SWRS_B1_CODE_LO];
        glob_q.prior_lock <= st_q.lock;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      st_q.ctl       <= `SWRS_RST_CTL;
      st_q.edge_rate <= `SWRS_RST_EDGE;
    end
    else if (ce_in && b2_go)
    begin
      st_q.ctl       <= dat_lq[`SWRS_B2_CTL_BIT];
      st_q.edge_rate <= dat_lq[`SWRS_B2_EDGE_BIT];
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      st_q.width <= swrs_pkg::swrs_width_e'(`SWRS_RST_WIDTH);
    else if (ce_in)
    begin
      if (b2_go)
        st_q.width <= swrs_pkg::swrs_width_e'(dat_lq[`SWRS_B2_WIDTH_HI:`SWRS_B2_WIDTH_LO]);
      else if (width_set_in)
        st_q.width <= width_val_in;
    end
  end

  // ready output: latched low once busy ends, so it cannot glitch back up
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      oe_q <= 1'b0;
      so_q <= 1'b0;
    end
    else if (ce_in)
    begin
      oe_q <= irq_s2 & ~csn_s2;
      if (!oe_q)
        so_q <= busy_in;
      else
        so_q <= so_q & busy_in;
    end
  end

  always_comb
  begin
    io_out    = 8'h00;
    io_oe_out = 8'h00;
    io_out[`SWRS_SO_LANE]    = so_q;
    io_oe_out[`SWRS_SO_LANE] = oe_q;
  end

  assign status_out = st_q;
  assign glob_out   = glob_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in || !ce_in);

  property p_wel_clear;
    (is_b1 || is_b2) && !wel_set_in |=> !st_q.write_latch_flag;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("write latch not cleared");

  property p_lock_update;
    b1_go |=> st_q.lock == $past(dat_lq[`SWRS_B1_LOCK_BIT]);
  endproperty
  a_lock_update: assert property (p_lock_update) else $error("lock not updated");

  property p_short_abort;
    is_b1 && !b1_full |=> $stable(st_q.lock) && !glob_q.req;
  endproperty
  a_short_abort: assert property (p_short_abort) else $error("short byte 1 write acted");

  property p_wp_block;
    is_b1 && !wp_s2 && !dat_lq[`SWRS_B1_LOCK_BIT] |=> $stable(st_q.lock) && !glob_q.req;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("lock cleared under write protect");

  property p_no_wel;
    is_b1 && !st_q.write_latch_flag |=> $stable(st_q.lock) && !glob_q.req;
  endproperty
  a_no_wel: assert property (p_no_wel) else $error("byte 1 write without latch");

  property p_glob;
    b1_go |=> glob_q.req && glob_q.prior_lock == $past(st_q.lock) && glob_q.code == $past(dat_lq[5:2]);
  endproperty
  a_glob: assert property (p_glob) else $error("global request wrong");

  property p_b2_abort;
    is_b2 && mod_lq != 3'h0 |=> $stable(st_q.ctl);
  endproperty
  a_b2_abort: assert property (p_b2_abort) else $error("misaligned byte 2 write acted");

  property p_b2_only;
    !b2_go |=> $stable(st_q.ctl) && $stable(st_q.edge_rate);
  endproperty
  a_b2_only: assert property (p_b2_only) else $error("byte 2 bits changed");

  property p_b2_write;
    b2_go && !wel_set_in |=> st_q.ctl == $past(dat_lq[`SWRS_B2_CTL_BIT]) && !st_q.write_latch_flag;
  endproperty
  a_b2_write: assert property (p_b2_write) else $error("byte 2 write not applied");

  property p_no_rise;
    oe_q && !so_q ##1 oe_q |-> !so_q;
  endproperty
  a_no_rise: assert property (p_no_rise) else $error("ready output rose");

  property p_float;
    csn_s2 |=> !io_oe_out[`SWRS_SO_LANE];
  endproperty
  a_float: assert property (p_float) else $error("output driven after release");

  property p_lanes;
    (io_oe_out & 8'hfd) == 8'h00;
  endproperty
  a_lanes: assert property (p_lanes) else $error("extra lane driven");

  c_b1_write: cover property (b1_go);
  c_b2_write: cover property (b2_go);
  c_ready_on: cover property (!oe_q ##1 oe_q);
  c_ready_fall: cover property (oe_q && so_q ##1 oe_q && !so_q);
  c_wp_block: cover property (is_b1 && b1_wp_block);
endmodule

// ---- swrs_host.sv ----
// host controller model: drives chip select, serial clock and data lanes
// assumes the bench calls its tasks; sck stands still outside frames
`timescale 1ns/10ps
module swrs_host (
  // serial link toward the device
  output logic       sck_out,
  output logic       cs_n_out,
  output logic [7:0] io_out
);
  initial
  begin
    sck_out = 1'b0;
    io_out = 8'h5a;
    // late first release so the device sees a real chip select edge
    #1 cs_n_out = 1'b1;
  end

  // msb first, w lanes per edge, lane w-1 first; cs stays low
  // wel must be set by the bench before writes
  // ready signalling used only while idle, level sensed inside
  task automatic open(input logic [23:0] vec, input int nbits, input int w);
    int k;
    int b;
    cs_n_out = 1'b0;
    #15;
    for (k = 0; k * w < nbits; k++)
    begin
      io_out = ~io_out;
      for (b = 0; b < w; b++)
        io_out[w-1-b] = vec[23-k*w-b];
      #15 sck_out = 1'b1;
      #15 sck_out = 1'b0;
    end
  endtask

  // released lanes never keep the last value
  task automatic close();
    io_out = ~io_out;
    cs_n_out = 1'b1;
  endtask

  task automatic frame(input logic [23:0] vec, input int nbits, input int w);
    open(vec, nbits, w);
    close();
  endtask
endmodule

// ---- swrs_top_tb.sv ----
// self-checking bench for the status write and ready signalling block
// assumes swrs_pkg, swrs_top and swrs_host are compiled before it
`timescale 1ns/10ps
module swrs_top_tb;
  logic                    ref_clk_in;
  logic                    srst_in;
  logic                    sck;
  logic                    cs_n;
  logic [7:0]              io_h;
  logic [7:0]              io_out;
  logic [7:0]              io_oe_out;
  logic                    wp_n_in;
  logic                    busy_in;
  logic                    wel_set_in;
  logic                    width_set_in;
  swrs_pkg::swrs_width_e   width_val_in;
  swrs_pkg::swrs_status_s  status_out;
  swrs_pkg::swrs_glob_s    glob_out;
  int                      errors;
  int                      n_checks;
  int                      n_req;
  int                      cyc;
  logic [3:0]              g_code;
  logic                    g_prior;

  swrs_host host (.sck_out(sck), .cs_n_out(cs_n), .io_out(io_h));

  swrs_top dut (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(1'b1),
    .sck_in(sck), .cs_n_in(cs_n), .io_in(io_h),
    .io_out(io_out), .io_oe_out(io_oe_out), .wp_n_in(wp_n_in),
    .busy_in(busy_in), .wel_set_in(wel_set_in), .width_set_in(width_set_in),
    .width_val_in(width_val_in), .status_out(status_out), .glob_out(glob_out)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // glob requests are one-cycle pulses, so count them here
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (glob_out.req === 1'b1)
    begin
      n_req++;
      g_code = glob_out.code;
      g_prior = glob_out.prior_lock;
    end
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic set_wel();
    cyc_wait(1);
    wel_set_in = 1'b1;
    cyc_wait(1);
    wel_set_in = 1'b0;
  endtask

  // frame then long enough for the release to reach the core
  task automatic wr(input logic [23:0] vec, input int nbits, input int w);
    host.frame(vec, nbits, w);
    cyc_wait(10);
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    srst_in = 1'b1;
    wp_n_in = 1'b1;
    busy_in = 1'b0;
    wel_set_in = 1'b0;
    width_set_in = 1'b0;
    width_val_in = swrs_pkg::SWRS_W_SINGLE;
    cyc_wait(3);
    srst_in = 1'b0;
    cyc_wait(2);
    chk("status", {2'h0, status_out}, 8'h00);
    chk("oe", io_oe_out, 8'h00);
    tend("reset");
    wr(24'h018000, 16, 1);
    chk("status", {2'h0, status_out}, 8'h00);
    chk("nreq", 8'(n_req), 8'h00);
    tend("no_wel");
    set_wel();
    chk("status", {2'h0, status_out}, 8'h10);
    // trailing zero byte would clear the lock if taken
    wr(24'h01bc00, 24, 1);
    chk("status", {2'h0, status_out}, 8'h20);
    chk("nreq", 8'(n_req), 8'h01);
    chk("code", {3'h0, g_prior, g_code}, 8'h0f);
    tend("lock_set");
    wp_n_in = 1'b0;
    cyc_wait(4);
    set_wel();
    wr(24'h010000, 16, 1);
    chk("status", {2'h0, status_out}, 8'h20);
    chk("nreq", 8'(n_req), 8'h01);
    wp_n_in = 1'b1;
    cyc_wait(4);
    set_wel();
    wr(24'h013c00, 16, 1);
    chk("status", {2'h0, status_out}, 8'h00);
    chk("code", {3'h0, g_prior, g_code}, 8'h1f);
    tend("protect");
    set_wel();
    wr(24'h018000, 12, 1);
    chk("status", {2'h0, status_out}, 8'h00);
    chk("nreq", 8'(n_req), 8'h02);
    tend("short_b1");
    set_wel();
    wr(24'h318900, 16, 1);
    chk("status", {2'h0, status_out}, 8'h0d);
    wr(24'h000000, 8, 4);
    set_wel();
    wr(24'h310000, 20, 4);
    chk("status", {2'h0, status_out}, 8'h0d);
    wr(24'h310000, 16, 4);
    chk("status", {2'h0, status_out}, 8'h0d);
    tend("byte2");
    busy_in = 1'b1;
    host.open(24'h250000, 24, 4);
    cyc_wait(8);
    chk("oe", io_oe_out, 8'h02);
    chk("so", {7'h0, io_out[1]}, 8'h01);
    chk("lanes", io_out & 8'hfd, 8'h00);
    busy_in = 1'b0;
    cyc_wait(3);
    chk("so", {7'h0, io_out[1]}, 8'h00);
    busy_in = 1'b1;
    cyc_wait(3);
    chk("so", {7'h0, io_out[1]}, 8'h00);
    host.close();
    cyc_wait(8);
    chk("oe", io_oe_out, 8'h00);
    tend("ready_quad");
    width_set_in = 1'b1;
    cyc_wait(1);
    width_set_in = 1'b0;
    cyc_wait(2);
    chk("status", {2'h0, status_out}, 8'h0c);
    wr(24'h000000, 2, 1);
    busy_in = 1'b0;
    // trailing byte of ones, clocked in the ready phase, must not matter
    host.open(24'h25ff00, 16, 1);
    cyc_wait(8);
    chk("oe", io_oe_out, 8'h02);
    chk("so", {7'h0, io_out[1]}, 8'h00);
    host.close();
    cyc_wait(8);
    chk("oe", io_oe_out, 8'h00);
    tend("ready_single");
    summarize();
  end
endmodule
